// >>> cis_pkg.sv
// constants shared by the current input status readout block
package cis_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int CODE_W = 12;
    localparam int UA_W = 16;
    localparam int NUM_CH = 4;

    ////////////////////////////////////////////////////////////////////////////
    // conversion figures, input current in microamperes
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;
    localparam logic [UA_W-1:0] UA_LIVE_ZERO = 16'h0FA0;
    localparam logic [UA_W-1:0] UA_FULL = 16'h4E20;
    localparam logic [UA_W-1:0] UA_SPAN_4_20 = 16'h3E80;
    localparam logic [UA_W-1:0] UA_SPAN_0_20 = 16'h4E20;
    localparam logic [UA_W-1:0] UA_OPEN_THRESH = 16'h0DAC;

    ////////////////////////////////////////////////////////////////////////////
    // status bit space
    localparam logic [ADDR_W-1:0] SS_RANGE_BASE = 12'h600;
    localparam logic [ADDR_W-1:0] SS_OPEN_BASE = 12'h610;
    localparam logic [ADDR_W-1:0] MS_RANGE_OFS = 12'h040;
    localparam logic [ADDR_W-1:0] MS_OPEN_OFS = 12'h050;
    localparam logic [ADDR_W-1:0] MS_SLOT_STEP = 12'h100;
    localparam logic [2:0] SLOT_SINGLE = 3'h0;
    localparam logic [2:0] SLOT_MAX = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // word registers
    localparam logic [ADDR_W-1:0] DATA_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] RANGE_CFG_ADDR = 12'h010;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h011;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h012;
    localparam logic [ADDR_W-1:0] SLOT_ADDR = 12'h013;
    localparam logic [NUM_CH-1:0] RANGE_CFG_RST = 4'hF;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam int IRQ_OPEN_LSB = 0;
    localparam int IRQ_DONE_LSB = 4;

endpackage : cis_pkg

// >>> cis_scaler.sv
// one channel: current sample to 12-bit code and open-signal flag
module cis_scaler
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [cis_pkg::UA_W-1:0] sample_ua_i,
    input wire logic sample_valid_i,
    input wire logic range_4_20_i,
    output logic [cis_pkg::CODE_W-1:0] code_o,
    output logic open_o,
    output logic done_o
);

    logic [cis_pkg::UA_W-1:0] clamped;
    logic [cis_pkg::UA_W-1:0] offset;
    logic [27:0] product;
    logic [27:0] quotient;
    logic [cis_pkg::CODE_W-1:0] code_ff;
    logic open_ff;
    logic done_ff;

    ////////////////////////////////////////////////////////////////////////////
    // linear scaling with clamp at both ends
    always_comb
    begin
        clamped = (sample_ua_i > cis_pkg::UA_FULL) ? cis_pkg::UA_FULL : sample_ua_i;
        if (range_4_20_i)
        begin
            // 4 mA gives 0, 20 mA gives full scale
            offset = (clamped > cis_pkg::UA_LIVE_ZERO) ? clamped - cis_pkg::UA_LIVE_ZERO : 16'h0000; // [RULE_07]
            product = 28'(offset) * 28'(cis_pkg::CODE_FULL);
            quotient = product / 28'(cis_pkg::UA_SPAN_4_20);
        end
        else
        begin
            offset = clamped;
            product = 28'(offset) * 28'(cis_pkg::CODE_FULL); // [RULE_08]
            quotient = product / 28'(cis_pkg::UA_SPAN_0_20);
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            code_ff <= 12'h000;
        end
        else if (sample_valid_i)
        begin
            code_ff <= quotient[cis_pkg::CODE_W-1:0]; // [RULE_06]
        end
    end

    // only a live-zero loop can tell a broken wire from a zero reading
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            open_ff <= 1'b0;
        end
        else if (sample_valid_i)
        begin
            open_ff <= range_4_20_i && (sample_ua_i < cis_pkg::UA_OPEN_THRESH); // [RULE_02]
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= sample_valid_i;
        end
    end

    assign code_o = code_ff;
    assign open_o = open_ff;
    assign done_o = done_ff;

endmodule // cis_scaler

// >>> cis_top.sv
// four-channel current input readout: data words, status bit space, interrupts
//
// The register offsets and the plain strobed port were left to the implementer.

// Behaviour
// [RULE_01] each channel has a range bit: 0 means 0-20 mA, 1 means 4-20 mA
// [RULE_02] each channel has an open bit: 1 when transmitter open, 0 when good; code sets it only in 4-20 mA range, below 3500 uA
// [RULE_03] single-slot host sees range bits at 600-603, open bits at 610-613
// [RULE_04] four-slot host sees range bits at N40-N43, open bits at N50-N53
// [RULE_05] conversion result is unsigned binary in low twelve bits of data word
// [RULE_06] codes run 0 to 4095, full scale is FFF
// [RULE_07] in 4-20 mA range, 4 mA is 0 and 20 mA is 4095, linear
// [RULE_08] in 0-20 mA range, code is 4095/20 times current in mA
// [RULE_09] upper four bits of every data word read as zero
module cis_top
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [2:0] SLOT_NUM_I,
    input wire logic [cis_pkg::NUM_CH*cis_pkg::UA_W-1:0] SAMPLE_UA_I,
    input wire logic [cis_pkg::NUM_CH-1:0] SAMPLE_VALID_I,
    input wire logic [cis_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [cis_pkg::DATA_W-1:0] WR_DATA_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    output logic [cis_pkg::DATA_W-1:0] RD_DATA_O,
    output logic IRQ_O
);

    localparam int NCH = cis_pkg::NUM_CH;

    logic [2:0] slot_meta_ff;
    logic [2:0] slot_sync_ff;
    logic [2:0] slot_ff;
    logic [NCH-1:0] range_cfg_ff;
    logic [NCH-1:0] open_flag;
    logic [NCH-1:0] open_prev_ff;
    logic [NCH-1:0] done_flag;
    logic [cis_pkg::CODE_W-1:0] code [NCH];
    logic [7:0] irq_status_ff;
    logic [7:0] irq_mask_ff;
    logic [7:0] irq_events;
    logic [cis_pkg::DATA_W-1:0] rd_data_ff;
    logic [cis_pkg::DATA_W-1:0] nxt_rd_data;
    logic irq_ff;
    logic status_rd;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // map a status bit address to channel and kind; ok low when unmapped
    function automatic logic [3:0] status_decode(input logic [cis_pkg::ADDR_W-1:0] a, input logic [2:0] slot);
        logic [cis_pkg::ADDR_W-1:0] rbase;
        logic [cis_pkg::ADDR_W-1:0] obase;
        logic [3:0] res;
        res = 4'h0;
        if (slot == cis_pkg::SLOT_SINGLE)
        begin
            rbase = cis_pkg::SS_RANGE_BASE; // [RULE_03]
            obase = cis_pkg::SS_OPEN_BASE;
        end
        else
        begin
            rbase = 12'(slot) * cis_pkg::MS_SLOT_STEP + cis_pkg::MS_RANGE_OFS; // [RULE_04]
            obase = 12'(slot) * cis_pkg::MS_SLOT_STEP + cis_pkg::MS_OPEN_OFS;
        end
        // res = {ok, is_open, channel}
        if (a >= rbase && a < rbase + 12'(NCH))
        begin
            res = {1'b1, 1'b0, 2'(a - rbase)};
        end
        else if (a >= obase && a < obase + 12'(NCH))
        begin
            res = {1'b1, 1'b1, 2'(a - obase)};
        end
        return res;
    endfunction

    function automatic logic is_data_addr(input logic [cis_pkg::ADDR_W-1:0] a);
        return a >= cis_pkg::DATA_BASE && a < cis_pkg::DATA_BASE + 12'(NCH);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // slot strap: synchronised, then held from reset release on
    always_ff @(posedge CLK_I)
    begin
        slot_meta_ff <= SLOT_NUM_I;
        slot_sync_ff <= slot_meta_ff;
    end

    // out of range slot numbers fall back to the single-slot map
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            slot_ff <= (slot_sync_ff > cis_pkg::SLOT_MAX) ? cis_pkg::SLOT_SINGLE : slot_sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            cis_scaler u_scaler
            (
                .CLK_I(CLK_I),
                .SYS_RST_I(SYS_RST_I),
                .sample_ua_i(SAMPLE_UA_I[g*cis_pkg::UA_W +: cis_pkg::UA_W]),
                .sample_valid_i(SAMPLE_VALID_I[g]),
                .range_4_20_i(range_cfg_ff[g]),
                .code_o(code[g]),
                .open_o(open_flag[g]),
                .done_o(done_flag[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // range configuration, one bit per channel, 1 selects 4-20 mA
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            range_cfg_ff <= cis_pkg::RANGE_CFG_RST;
        end
        else if (WR_STB_I && ADDR_I == cis_pkg::RANGE_CFG_ADDR)
        begin
            range_cfg_ff <= WR_DATA_I[NCH-1:0]; // [RULE_01]
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            irq_mask_ff <= cis_pkg::IRQ_MASK_RST;
        end
        else if (WR_STB_I && ADDR_I == cis_pkg::IRQ_MASK_ADDR)
        begin
            irq_mask_ff <= WR_DATA_I[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: open going high and conversion done, cleared by read
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            open_prev_ff <= '0;
        end
        else
        begin
            open_prev_ff <= open_flag;
        end
    end

    assign irq_events = {done_flag, open_flag & ~open_prev_ff};
    assign status_rd = RD_STB_I && ADDR_I == cis_pkg::IRQ_STATUS_ADDR;

    // a new event in the clearing cycle stays set
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            irq_status_ff <= 8'h00;
        end
        else if (status_rd)
        begin
            irq_status_ff <= irq_events;
        end
        else
        begin
            irq_status_ff <= irq_status_ff | irq_events;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe and zero otherwise
    always_comb
    begin
        logic [3:0] sd;
        sd = status_decode(ADDR_I, slot_ff);
        nxt_rd_data = 16'h0000;
        if (RD_STB_I)
        begin
            if (is_data_addr(ADDR_I))
            begin
                // [RULE_09]
                nxt_rd_data = {4'h0, code[2'(ADDR_I - cis_pkg::DATA_BASE)]}; // [RULE_05]
            end
            else if (sd[3])
            begin
                nxt_rd_data[0] = sd[2] ? open_flag[sd[1:0]] : range_cfg_ff[sd[1:0]]; // [RULE_01] [RULE_02]
            end
            else if (ADDR_I == cis_pkg::RANGE_CFG_ADDR)
            begin
                nxt_rd_data[NCH-1:0] = range_cfg_ff;
            end
            else if (ADDR_I == cis_pkg::IRQ_STATUS_ADDR)
            begin
                nxt_rd_data[7:0] = irq_status_ff;
            end
            else if (ADDR_I == cis_pkg::IRQ_MASK_ADDR)
            begin
                nxt_rd_data[7:0] = irq_mask_ff;
            end
            else if (ADDR_I == cis_pkg::SLOT_ADDR)
            begin
                nxt_rd_data[2:0] = slot_ff;
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            rd_data_ff <= 16'h0000;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign RD_DATA_O = rd_data_ff;
    assign IRQ_O = irq_ff;

endmodule // cis_top

// >>> cis_checker.sv
// checker: port-level assertions of the readout block
module cis_checker
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [2:0] SLOT_NUM_I,
    input wire logic [63:0] SAMPLE_UA_I,
    input wire logic [3:0] SAMPLE_VALID_I,
    input wire logic [11:0] ADDR_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    input wire logic [15:0] RD_DATA_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] rng_ff;
    logic [3:0] opn_ff;
    logic [7:0] msk_ff;
    logic [2:0] slt_ff;
    logic q_ff;
    logic sel;
    // status window: range bits at base, open bits at base plus 0x10
    assign sel = ADDR_I[11:5] == (slt_ff == 3'h0 ? 7'h30 : {1'b0, slt_ff, 3'h2}) && ADDR_I[3:2] == 2'h0;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            rng_ff <= 4'hF;
            msk_ff <= 8'h00;
            opn_ff <= 4'h0;
            slt_ff <= SLOT_NUM_I > 3'h4 ? 3'h0 : SLOT_NUM_I;
        end
        else
        begin
            if (WR_STB_I && ADDR_I == cis_pkg::RANGE_CFG_ADDR)
                rng_ff <= WR_DATA_I[3:0];
            if (WR_STB_I && ADDR_I == cis_pkg::IRQ_MASK_ADDR)
                msk_ff <= WR_DATA_I[7:0];
            for (int c = 0; c < 4; c++)
                if (SAMPLE_VALID_I[c])
                    opn_ff[c] <= rng_ff[c] && SAMPLE_UA_I[16*c+:16] < cis_pkg::UA_OPEN_THRESH;
        end
        q_ff <= ADDR_I[4] ? opn_ff[ADDR_I[1:0]] : rng_ff[ADDR_I[1:0]];
    end
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    sequence rd_rng; RD_STB_I && sel && !ADDR_I[4]; endsequence
    sequence rd_opn; RD_STB_I && sel && ADDR_I[4]; endsequence
    rd_idle_zero_a: assert property (!RD_STB_I |=> RD_DATA_O == 16'h0000)
        else $error("idle read data");
    data_top_zero_a: assert property (RD_STB_I && ADDR_I < 12'h004 |=> RD_DATA_O[15:12] == 4'h0)
        else $error("data upper bits");
    range_bit_a: assert property (rd_rng |=> RD_DATA_O == {15'h0000, q_ff})
        else $error("range bit");
    open_bit_a: assert property (rd_opn |=> RD_DATA_O == {15'h0000, q_ff})
        else $error("open bit");
    slot_reg_a: assert property (RD_STB_I && ADDR_I == cis_pkg::SLOT_ADDR |=>
        RD_DATA_O == {13'h0, slt_ff})
        else $error("slot value");
    unmapped_zero_a: assert property (RD_STB_I && ADDR_I > 12'h013 && ADDR_I < 12'h100 |=> RD_DATA_O == 16'h0000)
        else $error("unmapped read");
    mask_quiet_a: assert property ((msk_ff == 8'h00) [*3] |-> !IRQ_O)
        else $error("masked interrupt");
    done_irq_a: assert property (SAMPLE_VALID_I[0] && msk_ff[4] |-> ##[1:4] IRQ_O)
        else $error("missing interrupt");
endmodule // cis_checker

// >>> cis_host.sv
// host side: register bus master
module cis_host
(
    input wire logic clk_i,
    input wire logic [15:0] rd_data_i,
    output logic [11:0] addr_o = 12'h000,
    output logic [15:0] wr_data_o = 16'h0000,
    output logic wr_stb_o = 1'b0,
    output logic rd_stb_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= v;
        wr_stb_o <= 1'b1;
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_o <= a;
        rd_stb_o <= 1'b1;
        @(posedge clk_i);
        rd_stb_o <= 1'b0;
        #1 v = rd_data_i;
    endtask
endmodule // cis_host

// >>> tb_cis_top.sv
// testbench of the readout block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_cis_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic r; logic [15:0] u; logic [11:0] c; logic o;} cis_row_type;
    cis_row_type rows [10] = '{'{1'b1, 16'h0FA0, 12'h000, 1'b0}, '{1'b1, 16'h4E20, 12'hFFF, 1'b0},
        '{1'b1, 16'h2710, 12'h5FF, 1'b0}, '{1'b1, 16'h0DAB, 12'h000, 1'b1}, '{1'b1, 16'h0DAC, 12'h000, 1'b0},
        '{1'b1, 16'h61A8, 12'hFFF, 1'b0}, '{1'b0, 16'h0000, 12'h000, 1'b0}, '{1'b0, 16'h4E20, 12'hFFF, 1'b0},
        '{1'b0, 16'h2710, 12'h7FF, 1'b0}, '{1'b0, 16'h0BB8, 12'h266, 1'b0}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] slot = 3'h0;
    logic [63:0] ua = 64'h0;
    logic [3:0] vld = 4'h0;
    logic [11:0] addr, b;
    logic [15:0] wdat, rdat, d;
    logic wstb, rstb, irq;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    cis_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .SLOT_NUM_I(slot), .SAMPLE_UA_I(ua), .SAMPLE_VALID_I(vld),
        .ADDR_I(addr), .WR_DATA_I(wdat), .WR_STB_I(wstb), .RD_STB_I(rstb), .RD_DATA_O(rdat), .IRQ_O(irq));
    cis_host u_host (.clk_i(clk), .rd_data_i(rdat), .addr_o(addr), .wr_data_o(wdat), .wr_stb_o(wstb),
        .rd_stb_o(rstb));
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // strap settles through two flops, so reset spans four edges
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        slot <= s;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic smp(input int c, input logic [15:0] u);
        @(posedge clk);
        ua[16*c+:16] <= u;
        vld[c] <= 1'b1;
        @(posedge clk);
        vld <= 4'h0;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(3'h0);
        foreach (rows[i])
        begin
            u_host.wr(cis_pkg::RANGE_CFG_ADDR, {12'h000, {4{rows[i].r}}});
            smp(i % 4, rows[i].u);
            u_host.rd(cis_pkg::DATA_BASE + 12'(i % 4), d);
            `CHK(d, {4'h0, rows[i].c})
            u_host.rd(12'h600 + 12'(i % 4), d);
            `CHK(d, {15'h0000, rows[i].r})
            u_host.rd(12'h610 + 12'(i % 4), d);
            `CHK(d, {15'h0000, rows[i].o})
        end
        // reset values, unmapped space, interrupts
        do_reset(3'h0);
        u_host.rd(cis_pkg::RANGE_CFG_ADDR, d);
        `CHK(d, 16'h000F)
        u_host.rd(cis_pkg::IRQ_MASK_ADDR, d);
        `CHK(d, 16'h0000)
        u_host.wr(12'h020, 16'hFFFF);
        u_host.rd(12'h020, d);
        `CHK(d, 16'h0000)
        u_host.wr(cis_pkg::IRQ_MASK_ADDR, 16'h00F0);
        u_host.rd(cis_pkg::IRQ_MASK_ADDR, d);
        `CHK(d, 16'h00F0)
        smp(0, 16'h2710);
        `CHK(irq, 1'b1)
        u_host.rd(cis_pkg::IRQ_STATUS_ADDR, d);
        `CHK(d, 16'h0010)
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        u_host.wr(cis_pkg::IRQ_MASK_ADDR, 16'h0000);
        smp(2, 16'h0DAB);
        `CHK(irq, 1'b0)
        u_host.rd(cis_pkg::IRQ_STATUS_ADDR, d);
        `CHK(d, 16'h0044)
        // open rising unmasked, then a done event landing in the clearing cycle
        u_host.wr(cis_pkg::IRQ_MASK_ADDR, 16'h000F);
        smp(2, 16'h0FA0);
        `CHK(irq, 1'b0)
        u_host.rd(cis_pkg::IRQ_STATUS_ADDR, d);
        `CHK(d, 16'h0040)
        smp(2, 16'h0DAB);
        `CHK(irq, 1'b1)
        fork
            smp(1, 16'h2710);
            begin
                @(posedge clk);
                u_host.rd(cis_pkg::IRQ_STATUS_ADDR, d);
            end
        join
        `CHK(d, 16'h0044)
        u_host.rd(cis_pkg::IRQ_STATUS_ADDR, d);
        `CHK(d, 16'h0020)
        // slot maps, strap 5 falls back to the single-slot map
        for (int n = 1; n <= 5; n++)
        begin
            do_reset(3'(n));
            u_host.wr(cis_pkg::RANGE_CFG_ADDR, 16'h0005);
            smp(0, 16'h0BB8);
            u_host.rd(cis_pkg::SLOT_ADDR, d);
            `CHK(d, {13'h0, n < 5 ? 3'(n) : 3'h0})
            b = n < 5 ? {1'b0, 3'(n), 8'h40} : 12'h600;
            u_host.rd(b, d);
            `CHK(d, 16'h0001)
            u_host.rd(b + 12'h001, d);
            `CHK(d, 16'h0000)
            u_host.rd(b + 12'h010, d);
            `CHK(d, 16'h0001)
        end
        give_verdict();
    end
endmodule // tb_cis_top
bind cis_top cis_checker u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SLOT_NUM_I(SLOT_NUM_I),
    .SAMPLE_UA_I(SAMPLE_UA_I), .SAMPLE_VALID_I(SAMPLE_VALID_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O), .IRQ_O(IRQ_O));
